// >>> cfg_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module cfg_link_sva #(
	parameter logic [31:0] FEATURES   = 32'h00000110,
	parameter logic [31:0] DEST_LIMIT = 32'h000000FF,
	parameter logic [31:0] IMPL_VALUE = 32'h00000000
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        req,
	input wire logic        write,
	input wire logic [23:0] offset,
	input wire logic [31:0] wdata,
	input wire logic        done,
	input wire logic [31:0] rdata
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Unassigned words below the extended space
	function automatic logic rsv(input logic [23:0] o);
		return o[23:8] == 16'h0000 && !(o[7:2] inside
			{6'h04, 6'h0D, 6'h18, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E});
	endfunction : rsv
	// Read answers qualified by done; write is still held then
	wire logic rd_ans = done && !write;
	a_answer_next: assert property (req && !done |=> done)
		else $error("link request not answered next cycle");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_req_release: assert property (done |=> !req)
		else $error("request not dropped after done");
	a_req_hold: assert property (req && !done |=> $stable(offset)
		&& $stable(wdata) && $stable(write))
		else $error("request changed before done");
	a_rsv_zero: assert property (rd_ans && rsv(offset) |-> rdata == 0)
		else $error("reserved offset read not zero");
	a_car_value: assert property (rd_ans && offset[23:2] == 22'h4
		|-> rdata == FEATURES)
		else $error("features read wrong");
	a_limit_value: assert property (rd_ans && offset[23:2] == 22'hD
		|-> rdata == DEST_LIMIT)
		else $error("destination limit read wrong");
	a_ext_zero: assert property (rd_ans && offset inside
		{[24'h000100:24'h00FFFF]} |-> rdata == 0)
		else $error("extended space read not zero");
	a_impl_value: assert property (rd_ans && offset >= 24'h010000
		|-> rdata == IMPL_VALUE)
		else $error("implementation space read wrong");
	cover property (rd_ans && offset == 24'h000010);
	cover property (done && write && offset == 24'h000068);
	cover property (rd_ans && offset >= 24'h010000);
endmodule : cfg_link_sva
`default_nettype wire

// >>> cfg_space_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "cfg_space_params.svh"
module cfg_space_device import cfg_space_pkg::*; #(
	parameter logic [31:0] FEATURES   = 32'h00000110,
	parameter logic [31:0] DEST_LIMIT = 32'h000000FF,
	parameter logic [31:0] IMPL_VALUE = 32'h00000000
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	maint_if.device          link,
	output var  logic [31:0] route_dest_select,
	output var  logic [31:0] route_port_select,
	output var  logic [31:0] route_default_port,
	output var  logic [31:0] base_identifier
);
	typedef struct packed {
		logic        done;
		logic [31:0] rdata;
		logic [31:0] base_id;
		logic [15:0] host_lock;
		logic [31:0] comp_label;
		logic [31:0] dest_sel;
		logic [31:0] port_sel;
		logic [31:0] def_port;
	} dev_state_t;

	dev_state_t st;
	dev_state_t next_st;

	function automatic space_t space_of(input logic [23:0] ofs);
		if (ofs >= `OFS_IMPL_BASE) begin
			space_of = SP_IMPL;
		end else if (ofs >= `OFS_EXT_BASE) begin
			space_of = SP_EXT;
		end else if (ofs >= `OFS_CSR_BASE) begin
			space_of = SP_CSR;
		end else begin
			space_of = SP_CAR;
		end
	endfunction : space_of

	typedef enum logic [3:0] {
		SEL_NONE  = 4'h0,
		SEL_FEAT  = 4'h1,
		SEL_LIMIT = 4'h2,
		SEL_BASE  = 4'h3,
		SEL_LOCK  = 4'h4,
		SEL_LABEL = 4'h5,
		SEL_DSEL  = 4'h6,
		SEL_PSEL  = 4'h7,
		SEL_DPORT = 4'h8,
		SEL_IMPL  = 4'h9
	} reg_sel_t;

	// One decoder shared by read and write, so they cannot disagree
	function automatic reg_sel_t reg_of(input logic [23:0] ofs);
		if (ofs == `OFS_PE_FEATURES) begin
			reg_of = SEL_FEAT;
		end else if (ofs == `OFS_RT_DEST_LIMIT) begin
			reg_of = SEL_LIMIT;
		end else if (ofs == `OFS_BASE_ID) begin
			reg_of = SEL_BASE;
		end else if (ofs == `OFS_HOST_LOCK) begin
			reg_of = SEL_LOCK;
		end else if (ofs == `OFS_COMP_LABEL) begin
			reg_of = SEL_LABEL;
		end else if (ofs == `OFS_RT_DEST_SEL) begin
			reg_of = SEL_DSEL;
		end else if (ofs == `OFS_RT_PORT_SEL) begin
			reg_of = SEL_PSEL;
		end else if (ofs == `OFS_RT_DEF_PORT) begin
			reg_of = SEL_DPORT;
		end else if (space_of(ofs) == SP_IMPL) begin
			reg_of = SEL_IMPL;
		end else begin
			reg_of = SEL_NONE;
		end
	endfunction : reg_of

	// Write-once lock; only the owner's own id releases it
	function automatic logic [15:0] lock_next(input logic [15:0] cur,
		input logic [15:0] val);
		if (cur == `RST_HOST_LOCK) begin
			lock_next = val;
		end else if (cur == val) begin
			lock_next = `RST_HOST_LOCK;
		end else begin
			lock_next = cur;
		end
	endfunction : lock_next

	reg_sel_t    sel;
	logic [23:0] word_ofs;
	logic [31:0] read_val;
	assign word_ofs = {link.offset[23:2], 2'b00};
	assign sel      = reg_of(word_ofs);

	always_comb begin
		// Vector bit 31 carries big-endian bit 0
		read_val = 32'h00000000;
		case (sel)
			SEL_FEAT: begin
				read_val = FEATURES;
			end
			SEL_LIMIT: begin
				read_val = DEST_LIMIT;
			end
			SEL_BASE: begin
				read_val = st.base_id;
			end
			SEL_LOCK: begin
				read_val = {16'h0000, st.host_lock};
			end
			SEL_LABEL: begin
				read_val = st.comp_label;
			end
			SEL_DSEL: begin
				read_val = st.dest_sel;
			end
			SEL_PSEL: begin
				read_val = st.port_sel;
			end
			SEL_DPORT: begin
				read_val = st.def_port;
			end
			SEL_IMPL: begin
				read_val = IMPL_VALUE;
			end
			default: begin
				read_val = 32'h00000000;
			end
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (link.req && !st.done) begin
			next_st.done = 1'b1; // Always completes, never errors
			next_st.rdata = read_val;
			if (link.write) begin
				// Capability space has no write path at all
				case (sel)
					SEL_BASE: begin
						next_st.base_id = link.wdata & `BASE_ID_MASK;
					end
					SEL_LOCK: begin
						next_st.host_lock = lock_next(st.host_lock,
							link.wdata[15:0]);
					end
					SEL_LABEL: begin
						next_st.comp_label = link.wdata;
					end
					SEL_DSEL: begin
						next_st.dest_sel = link.wdata & `DEST_SEL_MASK;
					end
					SEL_PSEL: begin
						next_st.port_sel = link.wdata;
					end
					SEL_DPORT: begin
						next_st.def_port = link.wdata;
					end
					default: begin
						// Discarded, incl. extended space
					end
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st.done       <= 1'b0;
			st.rdata      <= 32'h00000000;
			st.base_id    <= `RST_BASE_ID;
			st.host_lock  <= `RST_HOST_LOCK;
			st.comp_label <= `RST_COMP_LABEL;
			st.dest_sel   <= `RST_ROUTE;
			st.port_sel   <= `RST_ROUTE;
			st.def_port   <= `RST_ROUTE;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign link.done          = st.done;
	assign link.rdata         = st.rdata;
	assign route_dest_select  = st.dest_sel;
	assign route_port_select  = st.port_sel;
	assign route_default_port = st.def_port;
	assign base_identifier    = st.base_id;
endmodule : cfg_space_device
`default_nettype wire

// >>> cfg_space_element.sv
`timescale 1ns/10ps
`default_nettype none
`include "cfg_space_params.svh"
module cfg_space_element import cfg_space_pkg::*; (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic [31:0] hrdata,
	maint_if.element         link
);
	typedef struct packed {
		host_state_t state;
		logic        dph;
		logic        dwr;
		logic [31:0] daddr;
		logic [23:0] addr;
		logic [31:0] wdata;
		logic [31:0] mask;
		logic        write;
		logic        busy;
		logic        req;
		logic [31:0] rdata;
		logic [31:0] hrdata;
	} host_st_t;

	host_st_t st;
	host_st_t next_st;

	always_comb begin
		next_st = st;
		next_st.req = 1'b0;
		// One-cycle address/data pipeline, zero wait states
		next_st.dph = hsel && hready && htrans[1];
		next_st.dwr = hwrite;
		next_st.daddr = haddr;
		if (hsel && hready && htrans[1] && !hwrite) begin
			if (haddr == `HOF_ADDR) begin
				next_st.hrdata = {8'h00, st.addr};
			end else if (haddr == `HOF_WDATA) begin
				next_st.hrdata = st.wdata;
			end else if (haddr == `HOF_CTRL) begin
				next_st.hrdata = st.mask;
			end else if (haddr == `HOF_STATUS) begin
				next_st.hrdata = {31'h00000000, st.busy};
			end else if (haddr == `HOF_RDATA) begin
				next_st.hrdata = st.rdata & st.mask;
			end else begin
				next_st.hrdata = 32'h00000000;
			end
		end
		if (st.dph && st.dwr) begin
			if (st.daddr == `HOF_ADDR) begin
				next_st.addr = {hwdata[23:2], 2'b00};
			end else if (st.daddr == `HOF_WDATA) begin
				next_st.wdata = hwdata;
			end else if (st.daddr == `HOF_CTRL) begin
				next_st.mask = hwdata;
			end else if (st.daddr == `HOF_STATUS && !st.busy) begin
				// Bit0 write, bit1 read; busy blocks new orders
				next_st.write = hwdata[0];
				next_st.busy = hwdata[0] | hwdata[1];
				next_st.state = H_IDLE;
			end
		end
		case (st.state)
			H_IDLE: begin
				if (st.busy) begin
					next_st.state = H_REQ;
					next_st.req = 1'b1;
				end
			end
			H_REQ: begin
				next_st.req = 1'b1;
				if (link.done) begin
					next_st.req = 1'b0;
					next_st.rdata = link.rdata;
					next_st.state = H_WAIT;
				end
			end
			default: begin
				next_st.busy = 1'b0;
				next_st.state = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
			st.mask <= 32'hFFFFFFFF;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// Software does read-merge-write through WDATA
	assign link.write   = st.write;
	assign link.offset  = st.addr;
	assign link.wdata   = st.wdata;
	assign link.req     = st.req;
	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;
	assign hrdata       = st.hrdata;
endmodule : cfg_space_element
`default_nettype wire

// >>> cfg_space_params.svh
`ifndef CFG_SPACE_PARAMS_SVH
`define CFG_SPACE_PARAMS_SVH
// Byte offsets in configuration space
`define OFS_PE_FEATURES      24'h000010
`define OFS_RT_DEST_LIMIT    24'h000034
`define OFS_BASE_ID          24'h000060
`define OFS_HOST_LOCK        24'h000068
`define OFS_COMP_LABEL       24'h00006C
`define OFS_RT_DEST_SEL      24'h000070
`define OFS_RT_PORT_SEL      24'h000074
`define OFS_RT_DEF_PORT      24'h000078
`define OFS_CSR_BASE         24'h000040
`define OFS_EXT_BASE         24'h000100
`define OFS_IMPL_BASE        24'h010000
// Field positions (big-endian bit n is vector bit 31-n)
`define HOST_LOCK_LSB        0
`define HOST_LOCK_W          16
`define BASE_ID_MASK         32'h00FFFFFF
`define DEST_SEL_MASK        32'hFFFFFFFF
// Reset values
`define RST_HOST_LOCK        16'hFFFF
`define RST_BASE_ID          32'h00000000
`define RST_COMP_LABEL       32'h00000000
`define RST_ROUTE            32'h00000000
// Host command register offsets (AHB-Lite side)
`define HOF_ADDR             32'h00000000
`define HOF_WDATA            32'h00000004
`define HOF_CTRL             32'h00000008
`define HOF_STATUS           32'h0000000C
`define HOF_RDATA            32'h00000010
`endif

// >>> cfg_space_pkg.sv
package cfg_space_pkg;
	typedef enum logic [1:0] {
		SP_CAR  = 2'h0,
		SP_CSR  = 2'h1,
		SP_EXT  = 2'h2,
		SP_IMPL = 2'h3
	} space_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_REQ  = 2'h1,
		H_WAIT = 2'h2
	} host_state_t;
endpackage : cfg_space_pkg

// >>> maint_if.sv
`timescale 1ns/10ps
`default_nettype none
interface maint_if;
	logic        req;
	logic        write;
	logic [23:0] offset;
	logic [31:0] wdata;
	logic        done;
	logic [31:0] rdata;
	modport device (input req, write, offset, wdata, output done, rdata);
	modport element (output req, write, offset, wdata, input done, rdata);
endinterface : maint_if
`default_nettype wire

// >>> transport_config_space_decoder_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "cfg_space_params.svh"
module transport_config_space_decoder_tb_top;
	localparam logic [31:0] IMPL = 32'h5A5A0001;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
	logic        ce = 1'b1;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, rd, d, x;
	wire logic        hreadyout, hresp;
	wire logic [31:0] hrdata, rds, rps, rdp, bid;
	int          errors = 0, n_tests = 0;
	integer      seed = 32'hC59A;
	logic [15:0] lock = 16'hFFFF;
	logic [31:0] m [logic [23:0]];
	logic [23:0] offs [19] = '{24'h0, 24'h10, 24'h14, 24'h34, 24'h38,
		24'h40, 24'h60, 24'h64, 24'h68, 24'h6C, 24'h70, 24'h74, 24'h78,
		24'h7C, 24'hFC, 24'h100, 24'hFFFC, 24'h10000, 24'hFFFFFC};
	maint_if link ();
	cfg_space_element i_cfg_space_element (.hclk(hclk), .hresetn(hresetn),
		.clk_en(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
	cfg_space_device #(.IMPL_VALUE(IMPL)) i_cfg_space_device (.hclk(hclk),
		.hresetn(hresetn), .clk_en(ce), .link(link),
		.route_dest_select(rds), .route_port_select(rps),
		.route_default_port(rdp), .base_identifier(bid));
	cfg_link_sva #(.IMPL_VALUE(IMPL)) i_cfg_link_sva (.hclk(hclk),
		.hresetn(hresetn), .req(link.req), .write(link.write),
		.offset(link.offset), .wdata(link.wdata), .done(link.done),
		.rdata(link.rdata));
	function automatic logic [31:0] exp(input logic [23:0] o);
		if (o == 24'h10) return 32'h00000110;
		if (o == 24'h34) return 32'h000000FF;
		if (o >= 24'h010000) return IMPL;
		if (o == 24'h68) return {16'h0, lock};
		return m.exists(o) ? m[o] : 32'h0;
	endfunction
	task automatic upd(input logic [23:0] o, input logic [31:0] v);
		if (o == 24'h68) begin
			lock = lock == 16'hFFFF ? v[15:0] : (v[15:0] == lock ? 16'hFFFF : lock);
		end else if (o == 24'h60) begin
			m[o] = v & `BASE_ID_MASK;
		end else if (o inside {24'h6C, 24'h70, 24'h74, 24'h78}) begin
			m[o] = v;
		end
	endtask : upd
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_tests++;
		if (got !== want) begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask : chk
	// Entered right after an edge, so back-to-back transfers need no gap
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : ahb
	task automatic mop(input logic w, input logic [23:0] o, input logic [31:0] wd);
		ahb(1, `HOF_ADDR, {8'h0, o});
		ahb(1, `HOF_WDATA, wd);
		ahb(1, `HOF_STATUS, w ? 32'h1 : 32'h2);
		rd = 1;
		repeat (20) if (rd[0]) ahb(0, `HOF_STATUS, 0);
		chk(rd & 32'h1, 32'h0);
		if (!w) ahb(0, `HOF_RDATA, 0);
	endtask : mop
	task automatic results;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results
	initial forever #5 hclk = ~hclk;
	initial begin
		repeat (20000) @(posedge hclk);
		errors++;
		results;
	end
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		foreach (offs[i]) begin
			mop(0, offs[i], 0);
			chk(rd, exp(offs[i]));
		end
		// First pass claims the lock, later random writes must bounce off
		repeat (3) foreach (offs[i]) begin
			d = $random(seed);
			mop(1, offs[i], d);
			upd(offs[i], d);
			mop(0, offs[i], 0);
			chk(rd, exp(offs[i]));
		end
		mop(0, 24'h6C, 0);
		x = (rd & 32'hFFFF0000) | 32'h0000A5C3;
		mop(1, 24'h6C, x);
		upd(24'h6C, x);
		mop(0, 24'h6C, 0);
		chk(rd, x);
		x = {16'h0, lock};
		mop(1, 24'h68, x);
		upd(24'h68, x);
		mop(0, 24'h68, 0);
		chk(rd, 32'h0000FFFF);
		// Frozen ends drop the transfer, so the mask stays open
		ce <= 1'b0;
		ahb(1, `HOF_CTRL, 32'h0000FFFF);
		ce <= 1'b1;
		mop(0, 24'h60, 0);
		chk(rd, exp(24'h60));
		ahb(1, `HOF_CTRL, 32'h0000FFFF);
		mop(0, 24'h60, 0);
		chk(rd, exp(24'h60) & 32'h0000FFFF);
		chk(bid, exp(24'h60));
		chk(rds, exp(24'h70));
		chk(rps, exp(24'h74));
		chk(rdp, exp(24'h78));
		results;
	end
endmodule : transport_config_space_decoder_tb_top
`default_nettype wire
